// ==== psp_pkg.sv ====
// Package with constants, types and shared arithmetic for the pulse output block.
//
// Function
// - Duty setting is fraction of 32000.
// - Setting 16000 gives half-period high time.
// - Full-scale duty holds output high always.
// - Zero duty holds output low always.
// - Frequency setting is given in hertz.
// - Each channel uses its own settings.
// - Move starts at start frequency, ramps up.
// - Run phase emits exactly run count pulses.
// - Decelerate over decel count, then stop.
// - Ready low during move, high when done.
// - Periods come from dividing 10 MHz reference.
// - Ramp step count of one flags error, refuses.
// - Start removed early aborts and flags error.
// - Error clears on next valid start.
package psp_pkg;

  localparam int unsigned CLK_HZ   = 100_000_000;
  localparam int unsigned REF_HZ   = 10_000_000;
  localparam int unsigned REF_DIV  = CLK_HZ / REF_HZ;
  localparam logic [31:0] DUTY_FULL = 32'h0000_7D00;
  localparam int          ADDR_W   = 5;
  localparam int          DATA_W   = 32;

  // Register index within a channel; channel number sits in ADDR[4:3].
  localparam logic [2:0] REG_DUTY_FS = 3'h0;
  localparam logic [2:0] REG_FREQ_FR = 3'h1;
  localparam logic [2:0] REG_ACCEL   = 3'h2;
  localparam logic [2:0] REG_RUN     = 3'h3;
  localparam logic [2:0] REG_DECEL   = 3'h4;
  localparam logic [2:0] REG_CTRL    = 3'h5;
  localparam logic [2:0] REG_STATUS  = 3'h6;

  // Control and status bit positions.
  localparam int CTRL_START = 0;
  localparam int CTRL_STEP  = 1;
  localparam int STAT_READY = 0;
  localparam int STAT_ERROR = 1;
  localparam int STAT_BUSY  = 2;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum {ST_IDLE, ST_ACCEL, ST_RUN, ST_DECEL, ST_HOLD} psp_step_e;

  // Settings of one channel as software wrote them.
  typedef struct packed {
    logic [31:0] duty_fs;
    logic [31:0] freq_fr;
    logic [31:0] accel;
    logic [31:0] run;
    logic [31:0] decel;
    logic        start;
    logic        step_mode;
  } psp_cfg_s;

  // Whole-number division; a zero divisor gives the largest value.
  function automatic logic [31:0] psp_div(input logic [63:0] a, input logic [31:0] b);
    logic [63:0] q;
    q = 64'h0;
    if (b == 32'h0) begin
      q = 64'hFFFF_FFFF;
    end else begin
      q = a / {32'h0, b};
    end
    psp_div = (q[63:32] != 32'h0) ? 32'hFFFF_FFFF : q[31:0];
  endfunction

  // Linear point between a and b at step i of n steps.
  function automatic logic [31:0] psp_lerp(input logic [31:0] a, input logic [31:0] b,
                                           input logic [31:0] i, input logic [31:0] n);
    logic signed [65:0] diff;
    logic signed [65:0] res;
    diff = $signed({2'b00, b, 32'h0}) - $signed({2'b00, a, 32'h0});
    res  = $signed({34'h0, a}) + ((diff >>> 32) * $signed({34'h0, i}))
           / $signed({34'h0, n - 32'h1});
    psp_lerp = res[31:0];
  endfunction

endpackage

// ==== psp_pulse_gen.sv ====
// Period and high-time pulse generator clocked from the 10 MHz reference tick.
module psp_pulse_gen (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        en,
  input  wire logic [31:0] per,
  input  wire logic [31:0] high,
  output logic             out,
  output logic             period_end
);
  import psp_pkg::*;

  logic [7:0]  pre_q;
  logic [31:0] cnt_q;
  logic [31:0] per_q;
  logic [31:0] high_q;
  logic        load_q;
  logic        en_q;
  logic        out_q;
  logic        tick;
  logic        last;
  logic [31:0] per_min;
  logic [31:0] high_now;

  // Reference tick every REF_DIV clocks; a period shorter than a tick is held at one.
  // reference tick divide
  assign tick    = (pre_q == 8'(REF_DIV - 1));
  assign per_min = (per == 32'h0) ? 32'h1 : per;
  assign last    = tick && (cnt_q + 32'h1 >= per_q);
  assign period_end = en_q && !load_q && last;
  assign out = out_q;
  // High time of the period being started uses the value that is loaded at this edge.
  assign high_now = load_q ? high : high_q;

  // Prescaler for the reference tick; it starts in step with the first load,
  // so that the first period after enable is as long as all the others.
  always_ff @(posedge clk) begin
    if (!rst_n || !en || !en_q) begin
      pre_q <= 8'h0;
    end else begin
      pre_q <= tick ? 8'h0 : pre_q + 8'h1;
    end
  end

  // Period counter; settings are reloaded one cycle after each period end.
  // reload each period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q  <= 32'h0;
      per_q  <= 32'h1;
      high_q <= 32'h0;
      load_q <= 1'b0;
      en_q   <= 1'b0;
    end else begin
      en_q   <= en;
      load_q <= en && (!en_q || period_end);
      if (!en) begin
        cnt_q <= 32'h0;
      end else if (load_q) begin
        per_q  <= per_min;
        high_q <= high;
      end else if (tick) begin
        cnt_q <= last ? 32'h0 : cnt_q + 32'h1;
      end
    end
  end

  // Registered output level; a stale high time never leaks into a new period.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else begin
      out_q <= en && en_q && (cnt_q < high_now);
    end
  end

endmodule

// ==== psp_top.sv ====
// Two-channel PWM and stepper profile pulse output with register port.
module psp_top #(
  parameter int NCH = 2
) (
  input  wire logic                        CLK,
  input  wire logic                        RST_N,
  input  wire logic [psp_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [psp_pkg::DATA_W-1:0]  WDATA,
  input  wire logic                        WE,
  input  wire logic                        RE,
  output logic      [psp_pkg::DATA_W-1:0]  RDATA,
  output logic      [NCH-1:0]              PULSE_OUT
);
  import psp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Register decode

  logic [1:0]  acc_ch;
  logic [2:0]  acc_reg;
  logic [31:0] rd_mux [NCH];
  logic [31:0] rdata_q;
  logic        ch_hit;

  // Channel and register index split out of the address.
  assign acc_ch  = ADDR[4:3];
  assign acc_reg = ADDR[2:0];
  assign ch_hit  = ({30'h0, acc_ch} < NCH);
  assign RDATA   = rdata_q;

  // Read data registered one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_q <= RST_WORD;
    end else if (RE && ch_hit) begin
      rdata_q <= rd_mux[acc_ch[0]];
    end else begin
      rdata_q <= RST_WORD;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channels

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gch
      psp_cfg_s    cfg_q;
      psp_step_e   state_q;
      psp_step_e   state_d;
      logic [31:0] idx_q;
      logic [31:0] idx_d;
      logic        err_q;
      logic        err_d;
      logic        start_d1_q;
      logic        wr;
      logic        start_rise;
      logic        bad;
      logic        active;
      logic        pe;
      logic        gen_out;
      logic        gen_en;
      logic [31:0] step_f;
      logic [31:0] step_per;
      logic [31:0] pwm_per;
      logic [31:0] pwm_high;
      logic [31:0] gen_per;
      logic [31:0] gen_high;
      logic [31:0] phase_len;
      logic        phase_last;
      logic        out_q;
      logic        pwm_full;
      logic        pwm_zero;

      // Write strobe for this channel.
      assign wr = WE && (acc_ch == 2'(g));

      // Software settings; each channel keeps its own copy.
      // per-channel settings
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          cfg_q <= '0;
        end else if (wr) begin
          case (acc_reg)
            REG_DUTY_FS: cfg_q.duty_fs <= WDATA;
            REG_FREQ_FR: cfg_q.freq_fr <= WDATA;
            REG_ACCEL:   cfg_q.accel   <= WDATA;
            REG_RUN:     cfg_q.run     <= WDATA;
            REG_DECEL:   cfg_q.decel   <= WDATA;
            REG_CTRL: begin
              cfg_q.start     <= WDATA[CTRL_START];
              cfg_q.step_mode <= WDATA[CTRL_STEP];
            end
            default: cfg_q <= cfg_q;
          endcase
        end
      end

      // Read-back of settings and live status.
      always_comb begin
        case (acc_reg)
          REG_DUTY_FS: rd_mux[g] = cfg_q.duty_fs;
          REG_FREQ_FR: rd_mux[g] = cfg_q.freq_fr;
          REG_ACCEL:   rd_mux[g] = cfg_q.accel;
          REG_RUN:     rd_mux[g] = cfg_q.run;
          REG_DECEL:   rd_mux[g] = cfg_q.decel;
          REG_CTRL:    rd_mux[g] = {30'h0, cfg_q.step_mode, cfg_q.start};
          REG_STATUS:  rd_mux[g] = {29'h0, active, err_q, !active};
          default:     rd_mux[g] = RST_WORD;
        endcase
      end

      // Start edge and parameter check; a ramp needs a nonzero start frequency.
      // ramp step count one refused
      assign start_rise = cfg_q.start && !start_d1_q && cfg_q.step_mode;
      assign bad = (cfg_q.accel == 32'h1) || (cfg_q.decel == 32'h1)
                   || (cfg_q.freq_fr == 32'h0)
                   || ((cfg_q.duty_fs == 32'h0)
                       && ((cfg_q.accel != 32'h0) || (cfg_q.decel != 32'h0)));
      assign active = (state_q == ST_ACCEL) || (state_q == ST_RUN)
                      || (state_q == ST_DECEL);

      // Step count of the current phase and whether this pulse closes it.
      assign phase_len = (state_q == ST_ACCEL) ? cfg_q.accel
                       : (state_q == ST_DECEL) ? cfg_q.decel : cfg_q.run;
      assign phase_last = (idx_q + 32'h1 >= phase_len);

      // Profile sequencer.
      always_comb begin
        state_d = state_q;
        idx_d   = idx_q;
        err_d   = err_q;
        case (state_q)
          ST_IDLE: begin
            if (start_rise) begin
              err_d = bad;
              if (!bad) begin
                idx_d   = 32'h0;
                state_d = (cfg_q.accel != 32'h0) ? ST_ACCEL
                        : (cfg_q.run != 32'h0) ? ST_RUN
                        : (cfg_q.decel != 32'h0) ? ST_DECEL : ST_HOLD;
              end
            end
          end
          ST_ACCEL, ST_RUN, ST_DECEL: begin
            if (!cfg_q.start) begin
              state_d = ST_IDLE;
              err_d   = 1'b1;
            end else if (pe) begin
              idx_d = idx_q + 32'h1;
              if (phase_last) begin
                idx_d = 32'h0;
                case (state_q)
                  ST_ACCEL: state_d = (cfg_q.run != 32'h0) ? ST_RUN
                                    : (cfg_q.decel != 32'h0) ? ST_DECEL : ST_HOLD;
                  ST_RUN:   state_d = (cfg_q.decel != 32'h0) ? ST_DECEL : ST_HOLD;
                  default:  state_d = ST_HOLD;
                endcase
              end
            end
          end
          ST_HOLD: begin
            if (!cfg_q.start) begin
              state_d = ST_IDLE;
            end
          end
          default: state_d = ST_IDLE;
        endcase
        if (!cfg_q.step_mode && active) begin
          state_d = ST_IDLE;
        end
      end

      // Sequencer state; ready is shown whenever no move is active.
      // ready low while moving
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          state_q    <= ST_IDLE;
          idx_q      <= RST_WORD;
          err_q      <= 1'b0;
          start_d1_q <= 1'b0;
        end else begin
          state_q    <= state_d;
          idx_q      <= idx_d;
          err_q      <= err_d;
          start_d1_q <= cfg_q.start;
        end
      end

      // Stepper frequency for the current step, linear across ramps.
      // ramp from start frequency
      always_comb begin
        case (state_q)
          ST_ACCEL: step_f = psp_lerp(cfg_q.duty_fs, cfg_q.freq_fr, idx_q, cfg_q.accel);
          ST_DECEL: step_f = psp_lerp(cfg_q.freq_fr, cfg_q.duty_fs, idx_q, cfg_q.decel);
          default:  step_f = cfg_q.freq_fr;
        endcase
      end

      // Periods are whole-number divisions of the reference rate.
      // integer divide of reference
      assign step_per = psp_div(64'(REF_HZ), step_f);
      assign pwm_per  = psp_div(64'(REF_HZ), cfg_q.freq_fr);
      assign pwm_high = psp_div({32'h0, pwm_per} * {32'h0, cfg_q.duty_fs}, DUTY_FULL);
      assign pwm_full = (cfg_q.duty_fs >= DUTY_FULL);
      assign pwm_zero = (cfg_q.duty_fs == 32'h0);

      // Generator steering for PWM or step mode; step pulses are half-period high.
      assign gen_en   = cfg_q.step_mode ? active
                                        : (cfg_q.freq_fr != 32'h0) && !pwm_full && !pwm_zero;
      assign gen_per  = cfg_q.step_mode ? step_per : pwm_per;
      assign gen_high = cfg_q.step_mode ? {1'b0, step_per[31:1]} : pwm_high;

      psp_pulse_gen u_gen (
        .clk        (CLK),
        .rst_n      (RST_N),
        .en         (gen_en),
        .per        (gen_per),
        .high       (gen_high),
        .out        (gen_out),
        .period_end (pe)
      );

      // Output pin with full and zero duty overrides in PWM mode.
      // full scale holds high
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          out_q <= 1'b0;
        end else if (!cfg_q.step_mode && pwm_full) begin
          out_q <= 1'b1;
        end else if (!cfg_q.step_mode && pwm_zero) begin
          out_q <= 1'b0;
        end else begin
          out_q <= gen_out;
        end
      end

      assign PULSE_OUT[g] = out_q;
    end
  endgenerate

endmodule

// ==== psp_chk_sva.sv ====
// Checker of the register port and status relations of the pulse output block.
module psp_chk #(
  parameter int NCH = 2
) (
  input wire logic                       CLK,
  input wire logic                       RST_N,
  input wire logic [psp_pkg::ADDR_W-1:0] ADDR,
  input wire logic [psp_pkg::DATA_W-1:0] WDATA,
  input wire logic                       WE,
  input wire logic                       RE,
  input wire logic [psp_pkg::DATA_W-1:0] RDATA,
  input wire logic [NCH-1:0]             PULSE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  import psp_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // A read strobe on one register index.
  sequence s_rd(logic [2:0] r);
    RE && ADDR[2:0] == r;
  endsequence
  // A write and a read of the same data register, back to back.
  sequence s_wr_rd;
    WE && ADDR[2:0] < REG_CTRL && ADDR[4:3] < NCH ##1 RE && $stable(ADDR);
  endsequence
  // A write and a read of the same control register, back to back.
  sequence s_ctl_rd;
    WE && ADDR[2:0] == REG_CTRL && ADDR[4:3] < NCH ##1 RE && $stable(ADDR);
  endsequence

  chk_rdata_idle: assert property (!RE |=> RDATA == '0)
    else $error("read data not zero outside the read slot");
  chk_reset_quiet: assert property ($rose(RST_N) |-> PULSE_OUT == '0 && RDATA == '0)
    else $error("outputs not quiet after reset");
  chk_data_readback: assert property (s_wr_rd |=> RDATA == $past(WDATA, 2))
    else $error("setting did not read back");
  chk_ctrl_readback: assert property (s_ctl_rd |=> (RDATA & 32'h3) == ($past(WDATA, 2) & 32'h3))
    else $error("control bits did not read back");
  chk_stat_upper: assert property (s_rd(REG_STATUS) |=> RDATA[31:3] == '0)
    else $error("status upper bits not zero");
  chk_busy_ready: assert property (s_rd(REG_STATUS) ##1 RDATA[2] |-> !RDATA[0])
    else $error("ready shown while busy");
  chk_rsvd_zero: assert property (s_rd(3'h7) |=> RDATA == '0)
    else $error("reserved index read not zero");
  chk_nochan_zero: assert property (RE && ADDR[4:3] >= NCH |=> RDATA == '0)
    else $error("absent channel read not zero");
endmodule

bind psp_top psp_chk #(.NCH(NCH)) u_chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
  .WE(WE), .RE(RE), .RDATA(RDATA), .PULSE_OUT(PULSE_OUT));

// ==== psp_load.sv ====
// Load model that times the pulses arriving on one output.
module psp_load (
  input  wire logic clk,
  input  wire logic pulse,
  output int        n_rise,
  output int        hi_len,
  output int        per_len
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt;
  logic last;

  // Start from a quiet line.
  initial begin
    n_rise  = 0;
    hi_len  = 0;
    per_len = 0;
    cnt     = 0;
    last    = 1'b0;
  end

  // Clocks since the last rise give the period; the fall latches the high time.
  always @(posedge clk) begin
    last <= pulse;
    cnt  <= cnt + 1;
    if (pulse && !last) begin
      n_rise  <= n_rise + 1;
      per_len <= cnt;
      cnt     <= 1;
    end
    if (!pulse && last) begin
      hi_len <= cnt;
    end
  end
endmodule

// ==== tb_psp_top.sv ====
// Self-checking bench for the two-channel pulse output block.
module tb_psp_top;
  timeunit 1ns;
  timeprecision 1ps;
  import psp_pkg::*;
  logic              CLK;
  logic              RST_N;
  logic              WE;
  logic              RE;
  logic [ADDR_W-1:0] ADDR;
  logic [DATA_W-1:0] WDATA;
  logic [DATA_W-1:0] RDATA;
  logic [1:0]        PULSE_OUT;
  int                n_mismatch;
  int                comparisons;
  int                cyc;
  int                base;
  int                nr[2];
  int                hi[2];
  int                pe[2];

  psp_top #(.NCH(2)) uut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WE(WE),
                          .RE(RE), .RDATA(RDATA), .PULSE_OUT(PULSE_OUT));
  psp_load ld0 (.clk(CLK), .pulse(PULSE_OUT[0]), .n_rise(nr[0]), .hi_len(hi[0]), .per_len(pe[0]));
  psp_load ld1 (.clk(CLK), .pulse(PULSE_OUT[1]), .n_rise(nr[1]), .hi_len(hi[1]), .per_len(pe[1]));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run.
  task automatic test_done();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Compare one value and report a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write a register, read it back in the next cycle and compare.
  task automatic wr_rd(input int ch, input logic [2:0] r, input logic [31:0] d);
    ADDR  <= {ch[1:0], r};
    WDATA <= d;
    WE    <= 1'b1;
    @(posedge CLK);
    WE <= 1'b0;
    RE <= 1'b1;
    @(posedge CLK);
    RE <= 1'b0;
    #1;
    chk(RDATA & ((r == REG_CTRL) ? 32'h3 : 32'hFFFF_FFFF), d);
    @(posedge CLK);
  endtask

  // One read; the data stand only in the cycle after the strobe.
  task automatic rd(input int ch, input logic [2:0] r, output logic [31:0] q);
    ADDR <= {ch[1:0], r};
    RE   <= 1'b1;
    @(posedge CLK);
    RE <= 1'b0;
    #1 q = RDATA;
    @(posedge CLK);
  endtask

  // Read and compare the masked bits.
  task automatic rdc(input int ch, input logic [2:0] r, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    rd(ch, r, q);
    chk(q & m, e);
  endtask

  // Wait, bounded, until a channel has shown n more rising edges.
  task automatic rises(input int c, input int n);
    int b;
    b = nr[c];
    for (int i = 0; i < 20000 && nr[c] < b + n; i++) @(posedge CLK);
  endtask

  // Poll the status, bounded, until the move reports done.
  task automatic wait_ready(input int ch);
    logic [31:0] q;
    q = 32'h0;
    for (int i = 0; i < 3000 && q[0] !== 1'b1; i++) rd(ch, REG_STATUS, q);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running clock and a bounded run length.
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      test_done();
    end
  end

  // Main sequence.
  initial begin
    RST_N = 1'b0;
    WE = 1'b0;
    RE = 1'b0;
    ADDR = '0;
    WDATA = '0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    // Reset values, absent channel and reserved index.
    rdc(0, REG_DUTY_FS, 32'hFFFF_FFFF, RST_WORD);
    rdc(0, REG_STATUS, 32'h7, 32'h1);
    rdc(2, REG_FREQ_FR, 32'hFFFF_FFFF, 32'h0);
    rdc(0, 3'h7, 32'hFFFF_FFFF, 32'h0);
    // Both channels at 100 kHz, half and nine tenths duty.
    wr_rd(0, REG_FREQ_FR, 32'h0001_86A0);
    wr_rd(0, REG_DUTY_FS, 32'h0000_3E80);
    wr_rd(1, REG_FREQ_FR, 32'h0001_86A0);
    wr_rd(1, REG_DUTY_FS, 32'h0000_7080);
    rises(0, 3);
    chk(pe[0], 32'h0000_03E8);
    chk(hi[0], 32'h0000_01F4);
    rises(1, 2);
    chk(pe[1], 32'h0000_03E8);
    chk(hi[1], 32'h0000_0384);
    // Zero duty holds low, full scale holds high.
    wr_rd(0, REG_DUTY_FS, 32'h0);
    wr_rd(1, REG_DUTY_FS, DUTY_FULL);
    repeat (2500) @(posedge CLK);
    base = nr[0] + nr[1];
    repeat (1500) @(posedge CLK);
    chk(nr[0] + nr[1] - base, 32'h0);
    chk({30'h0, PULSE_OUT}, 32'h2);
    // Stepper move from 500 kHz up to 1 MHz: ramp 3, run 4, ramp down 3.
    wr_rd(0, REG_CTRL, 32'h2);
    wr_rd(0, REG_DUTY_FS, 32'h0007_A120);
    wr_rd(0, REG_FREQ_FR, 32'h000F_4240);
    wr_rd(0, REG_ACCEL, 32'h3);
    wr_rd(0, REG_RUN, 32'h4);
    wr_rd(0, REG_DECEL, 32'h3);
    base = nr[0];
    rdc(0, REG_STATUS, 32'h1, 32'h1);
    wr_rd(0, REG_CTRL, 32'h3);
    rdc(0, REG_STATUS, 32'h7, 32'h4);
    rises(0, 2);
    chk(pe[0], 32'h0000_00C8);
    rises(0, 1);
    chk(pe[0], 32'h0000_0082);
    rises(0, 1);
    chk(pe[0], 32'h0000_0064);
    wait_ready(0);
    chk(nr[0] - base, 32'hA);
    rdc(0, REG_STATUS, 32'h7, 32'h1);
    wr_rd(0, REG_CTRL, 32'h2);
    // A one-step ramp is refused; a corrected start clears the flag.
    wr_rd(0, REG_ACCEL, 32'h1);
    wr_rd(0, REG_CTRL, 32'h3);
    repeat (4) @(posedge CLK);
    rdc(0, REG_STATUS, 32'h7, 32'h3);
    wr_rd(0, REG_ACCEL, 32'h0);
    wr_rd(0, REG_CTRL, 32'h2);
    wr_rd(0, REG_CTRL, 32'h3);
    repeat (4) @(posedge CLK);
    rdc(0, REG_STATUS, 32'h7, 32'h4);
    // Dropping start in mid-move stops the pulses and flags the fault.
    repeat (300) @(posedge CLK);
    wr_rd(0, REG_CTRL, 32'h2);
    repeat (4) @(posedge CLK);
    base = nr[0];
    rdc(0, REG_STATUS, 32'h2, 32'h2);
    repeat (300) @(posedge CLK);
    chk(nr[0] - base, 32'h0);
    chk({31'h0, PULSE_OUT[0]}, 32'h0);
    test_done();
  end
endmodule
